// >>> verilog/boot_address_select_pkg.sv
// Constants, encodings and register map for the boot address selector.
package boot_address_select_pkg;

   // ==========================================================================
   // Widths
   // ==========================================================================
   localparam int FIELD_W = 25;
   localparam int ADDR_W = 32;
   localparam int FIELD_LSB = 7;
   localparam int CMD_W = 8;
   localparam int PADDR_W = 12;

   // ==========================================================================
   // Fixed addresses and factory default fields
   // ==========================================================================
   localparam logic [ADDR_W-1:0] FLASH_BASE = 32'h0800_0000;
   localparam logic [ADDR_W-1:0] FLASH_LAST = 32'h080F_FFFF;
   localparam logic [ADDR_W-1:0] SECURE_FLASH_BASE = 32'h0C00_0000;
   localparam logic [ADDR_W-1:0] SECURE_FLASH_LAST = 32'h0C0F_FFFF;
   localparam logic [ADDR_W-1:0] SERVICES_ENTRY = 32'h0FF8_0000;
   localparam logic [ADDR_W-1:0] BOOTLOADER_ENTRY = 32'h0BF8_F000;
   localparam logic [FIELD_W-1:0] DEFAULT_FIELD_A = FLASH_BASE[ADDR_W-1:FIELD_LSB];
   localparam logic [FIELD_W-1:0] DEFAULT_FIELD_B = BOOTLOADER_ENTRY[ADDR_W-1:FIELD_LSB];
   localparam logic [FIELD_W-1:0] DEFAULT_FIELD_S = SECURE_FLASH_BASE[ADDR_W-1:FIELD_LSB];

   // ==========================================================================
   // Protection levels
   // ==========================================================================
   localparam logic [1:0] PROT_L0 = 2'h0;
   localparam logic [1:0] PROT_L0_5 = 2'h1;
   localparam logic [1:0] PROT_L1 = 2'h2;
   localparam logic [1:0] PROT_L2 = 2'h3;

   // ==========================================================================
   // Boot sources
   // ==========================================================================
   localparam logic [2:0] SRC_NONSECURE_A = 3'h0;
   localparam logic [2:0] SRC_NONSECURE_B = 3'h1;
   localparam logic [2:0] SRC_SECURE = 3'h2;
   localparam logic [2:0] SRC_SERVICES = 3'h3;
   localparam logic [2:0] SRC_FORCED_FLASH = 3'h4;

   // ==========================================================================
   // Register map and fields
   // ==========================================================================
   localparam logic [PADDR_W-1:0] REG_BOOT_ADDRESS = 12'h000;
   localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
   localparam logic [PADDR_W-1:0] REG_CONTROL = 12'h008;
   localparam logic [PADDR_W-1:0] REG_OPTIONS = 12'h00C;
   localparam int ST_VALID = 0;
   localparam int ST_SRC_LSB = 1;
   localparam int ST_SECURE = 4;
   localparam int ST_FORCED = 5;
   localparam int CTL_REEVALUATE = 0;
   localparam int SETTLE_CYCLES = 2;

   typedef enum logic [1:0] {
      ST_SETTLE,
      ST_DECIDE,
      ST_HOLD
   } phase_e;

endpackage

// >>> verilog/boot_address_select.sv
// Boot address selector: picks the first fetch address once per system reset.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// ============================================================================
// Summary of operation
// - Boot address comes from pin, option bits and 25-bit address fields.
// - Boot select is the pin or an option bit, chosen by a choice bit.
// - Targets are user flash, bootloader, SRAM, or root security services.
// - Nonsecure, choice 1: pin 0 picks field A, pin 1 picks B.
// - Nonsecure, choice 0: option 1 picks field A, option 0 picks B.
// - Factory field A is flash 0x0800_0000, field B the bootloader.
// - With security on, the secure field is the user source.
// - Security on and lock set: secure field; pin, option and command ignored.
// - Secure, unlocked, no command, choice 1: pin 0 secure, 1 services.
// - Secure, unlocked, no command, choice 0: option 1 secure, 0 services.
// - Secure and unlocked: nonzero services command forces services boot.
// - Factory secure field points to secure flash 0x0C00_0000.
// - Protection level 0 accepts any programmed address.
// - Secure, level 0.5 up: only services entry or secure flash allowed.
// - Secure, protected: disallowed address replaced by services entry.
// - Nonsecure level 2: only flash range allowed, else 0x0800_0000.
// - Services target only selectable when security is enabled.
// - Core starts secure, so boot address is secure.
module boot_address_select (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_boot_select_pin,
   input wire logic i_options_valid,
   input wire logic i_boot_select_option,
   input wire logic i_pin_or_option_choice,
   input wire logic i_security_enable_option,
   input wire logic i_boot_lock_option,
   input wire logic [1:0] i_readout_protection_level,
   input wire logic [boot_address_select_pkg::FIELD_W-1:0] i_nonsecure_boot_address_a,
   input wire logic [boot_address_select_pkg::FIELD_W-1:0] i_nonsecure_boot_address_b,
   input wire logic [boot_address_select_pkg::FIELD_W-1:0] i_secure_boot_address,
   input wire logic [boot_address_select_pkg::CMD_W-1:0] i_services_command,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [boot_address_select_pkg::PADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [boot_address_select_pkg::ADDR_W-1:0] o_boot_address,
   output logic o_boot_valid,
   output logic [2:0] o_boot_source,
   output logic o_address_forced,
   output logic o_start_secure
);
   import boot_address_select_pkg::*;

   // =========================================================================
   // Pin synchroniser
   // =========================================================================
   logic pin_meta;
   logic pin_sync;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= i_boot_select_pin;
         pin_sync <= pin_meta;
      end
   end

   // =========================================================================
   // Helpers
   // =========================================================================
   function automatic logic in_range(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (addr >= lo) && (addr <= hi);
   endfunction

   function automatic logic [ADDR_W-1:0] field_to_addr(input logic [FIELD_W-1:0] f);
      field_to_addr = {f, {FIELD_LSB{1'b0}}};
   endfunction

   // =========================================================================
   // Decision logic
   // =========================================================================
   logic [FIELD_W-1:0] field_a;
   logic [FIELD_W-1:0] field_b;
   logic [FIELD_W-1:0] field_s;
   logic select_one;
   logic [ADDR_W-1:0] next_boot_address;
   logic [2:0] next_boot_source;
   logic next_forced;

   // Blank option storage falls back to factory fields so a fresh part still boots.
   assign field_a = i_options_valid ? i_nonsecure_boot_address_a : DEFAULT_FIELD_A;
   assign field_b = i_options_valid ? i_nonsecure_boot_address_b : DEFAULT_FIELD_B;
   assign field_s = i_options_valid ? i_secure_boot_address : DEFAULT_FIELD_S;

   // The option bit is active low in sense: option 1 acts like pin 0.
   assign select_one = i_pin_or_option_choice ? pin_sync : !i_boot_select_option;

   always_comb begin
      next_boot_address = field_to_addr(field_a);
      next_boot_source = SRC_NONSECURE_A;
      next_forced = 1'b0;
      if (i_security_enable_option) begin
         if (i_boot_lock_option) begin
            next_boot_address = field_to_addr(field_s);
            next_boot_source = SRC_SECURE;
         end else if (i_services_command != '0) begin
            next_boot_address = SERVICES_ENTRY;
            next_boot_source = SRC_SERVICES;
         end else if (select_one) begin
            next_boot_address = SERVICES_ENTRY;
            next_boot_source = SRC_SERVICES;
         end else begin
            next_boot_address = field_to_addr(field_s);
            next_boot_source = SRC_SECURE;
         end
         if (i_readout_protection_level != PROT_L0 &&
             next_boot_address != SERVICES_ENTRY &&
             !in_range(next_boot_address, SECURE_FLASH_BASE, SECURE_FLASH_LAST)) begin
            next_boot_address = SERVICES_ENTRY;
            next_boot_source = SRC_SERVICES;
            next_forced = 1'b1;
         end
      end else begin
         if (select_one) begin
            next_boot_address = field_to_addr(field_b);
            next_boot_source = SRC_NONSECURE_B;
         end
         if (i_readout_protection_level == PROT_L2 &&
             !in_range(next_boot_address, FLASH_BASE, FLASH_LAST)) begin
            next_boot_address = FLASH_BASE;
            next_boot_source = SRC_FORCED_FLASH;
            next_forced = 1'b1;
         end
         // Levels below 2 keep the programmed address untouched.
      end
   end
   // level 0 never enters either replacement branch above.

   // =========================================================================
   // Sequencing
   // =========================================================================
   phase_e phase;
   logic [1:0] settle_count;
   logic reevaluate_req;
   logic [11:0] option_snapshot;

   // Waiting for the synchroniser keeps a reset-time pin level from being missed.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase <= ST_SETTLE;
         settle_count <= 2'h0;
      end else begin
         case (phase)
            ST_SETTLE: begin
               if (settle_count == 2'(SETTLE_CYCLES - 1)) begin
                  phase <= ST_DECIDE;
                  settle_count <= 2'h0;
               end else begin
                  settle_count <= settle_count + 2'h1;
               end
            end
            ST_DECIDE: begin
               phase <= ST_HOLD;
            end
            ST_HOLD: begin
               if (reevaluate_req) begin
                  phase <= ST_SETTLE;
               end
            end
            default: begin
               phase <= ST_SETTLE;
               settle_count <= 2'h0;
            end
         endcase
      end
   end

   // The result is latched in ST_DECIDE; later pin or option changes are ignored until a reevaluation.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_boot_address <= '0;
         o_boot_source <= SRC_NONSECURE_A;
         o_address_forced <= 1'b0;
         o_boot_valid <= 1'b0;
         o_start_secure <= 1'b0;
         option_snapshot <= '0;
      end else if (phase == ST_DECIDE) begin
         o_boot_address <= next_boot_address;
         o_boot_source <= next_boot_source;
         o_address_forced <= next_forced;
         o_boot_valid <= 1'b1;
         o_start_secure <= 1'b1;
         option_snapshot <= {i_services_command[3:0], i_readout_protection_level,
                             i_boot_lock_option, i_security_enable_option,
                             i_pin_or_option_choice, i_boot_select_option,
                             pin_sync, i_options_valid};
      end else if (phase == ST_HOLD && reevaluate_req) begin
         o_boot_valid <= 1'b0;
      end
   end

   // =========================================================================
   // APB slave
   // =========================================================================
   logic setup_phase;
   logic access_done;
   logic addr_mapped;
   logic addr_writable;

   assign setup_phase = i_psel && !i_penable;
   assign access_done = i_psel && i_penable && o_pready;
   assign addr_mapped = (i_paddr == REG_BOOT_ADDRESS) || (i_paddr == REG_STATUS) ||
                        (i_paddr == REG_CONTROL) || (i_paddr == REG_OPTIONS);
   assign addr_writable = (i_paddr == REG_CONTROL);

   // No wait state: ready rises in the first access cycle.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= setup_phase;
         o_pslverr <= setup_phase && (!addr_mapped || (i_pwrite && !addr_writable));
         o_prdata <= '0;
         if (setup_phase && !i_pwrite) begin
            case (i_paddr)
               REG_BOOT_ADDRESS: o_prdata <= o_boot_address;
               REG_STATUS: begin
                  o_prdata[ST_VALID] <= o_boot_valid;
                  o_prdata[ST_SRC_LSB +: 3] <= o_boot_source;
                  o_prdata[ST_SECURE] <= o_start_secure;
                  o_prdata[ST_FORCED] <= o_address_forced;
               end
               REG_OPTIONS: o_prdata[11:0] <= option_snapshot;
               default: o_prdata <= '0;
            endcase
         end
      end
   end

   // Reevaluation stands in for a system reset of this block only.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         reevaluate_req <= 1'b0;
      end else if (access_done && i_pwrite && i_paddr == REG_CONTROL) begin
         reevaluate_req <= i_pwdata[CTL_REEVALUATE];
      end else if (phase == ST_HOLD) begin
         reevaluate_req <= 1'b0;
      end
   end

endmodule

// >>> verification/boot_core_model.sv
// Model of the core that takes its first fetch address from the selector.
`timescale 1ns/1ps
module boot_core_model (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [31:0] i_boot_address,
   input wire logic i_boot_valid,
   input wire logic i_start_secure,
   output logic [31:0] o_fetch_address
);
   // ==========================================================================
   // First fetch
   // ==========================================================================
   // The core only fetches from its secure start state, so a missing flag shows as no fetch.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_fetch_address <= 32'hFFFF_FFFF;
      end else if (i_boot_valid && i_start_secure) begin
         o_fetch_address <= i_boot_address;
      end
   end
endmodule

// >>> verification/boot_address_select_sva.sv
// Checker of the boot address selector's port behaviour.
`timescale 1ns/1ps
module boot_address_select_sva (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_boot_select_pin,
   input wire logic i_options_valid,
   input wire logic i_boot_select_option,
   input wire logic i_pin_or_option_choice,
   input wire logic i_security_enable_option,
   input wire logic i_boot_lock_option,
   input wire logic [1:0] i_readout_protection_level,
   input wire logic [boot_address_select_pkg::FIELD_W-1:0] i_nonsecure_boot_address_a,
   input wire logic [boot_address_select_pkg::CMD_W-1:0] i_services_command,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic [boot_address_select_pkg::ADDR_W-1:0] o_boot_address,
   input wire logic o_boot_valid,
   input wire logic [2:0] o_boot_source,
   input wire logic o_start_secure
);
   import boot_address_select_pkg::*;
   // ==========================================================================
   // Decision and APB ready checks
   // ==========================================================================
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_valid_time: assert property ($rose(i_reset_n) |-> !o_boot_valid ##[1:4] o_boot_valid)
      else $error("boot valid not raised in time");
   a_nonsec_pin: assert property ($rose(o_boot_valid) && !i_security_enable_option
      && i_pin_or_option_choice && i_readout_protection_level != PROT_L2
      |-> o_boot_source == (i_boot_select_pin ? SRC_NONSECURE_B : SRC_NONSECURE_A))
      else $error("pin selected wrong nonsecure field");
   a_nonsec_opt: assert property ($rose(o_boot_valid) && !i_security_enable_option
      && !i_pin_or_option_choice && i_readout_protection_level != PROT_L2
      |-> o_boot_source == (i_boot_select_option ? SRC_NONSECURE_A : SRC_NONSECURE_B))
      else $error("option selected wrong nonsecure field");
   a_secure_sel: assert property ($rose(o_boot_valid) && i_security_enable_option
      && !i_boot_lock_option && i_services_command == 8'h00 && i_readout_protection_level == PROT_L0
      |-> o_boot_source == ((i_pin_or_option_choice ? !i_boot_select_pin : i_boot_select_option)
      ? SRC_SECURE : SRC_SERVICES))
      else $error("secure selection wrong");
   a_cmd_services: assert property ($rose(o_boot_valid) && i_security_enable_option
      && !i_boot_lock_option && i_services_command != 8'h00
      |-> o_boot_source == SRC_SERVICES && o_boot_address == SERVICES_ENTRY)
      else $error("services command not honoured");
   a_lock_secure: assert property ($rose(o_boot_valid) && i_security_enable_option
      && i_boot_lock_option && i_readout_protection_level == PROT_L0
      |-> o_boot_source == SRC_SECURE)
      else $error("lock did not force secure field");
   a_field_map: assert property ($rose(o_boot_valid) && o_boot_source == SRC_NONSECURE_A
      && i_options_valid |-> o_boot_address == {i_nonsecure_boot_address_a, 7'h00})
      else $error("field not placed in address bits 31 to 7");
   a_secure_range: assert property ($rose(o_boot_valid) && i_security_enable_option
      && i_readout_protection_level != PROT_L0 |-> o_boot_address == SERVICES_ENTRY
      || (o_boot_address >= SECURE_FLASH_BASE && o_boot_address <= SECURE_FLASH_LAST))
      else $error("protected secure boot outside allowed space");
   a_flash_range: assert property ($rose(o_boot_valid) && !i_security_enable_option
      && i_readout_protection_level == PROT_L2
      |-> o_boot_address >= FLASH_BASE && o_boot_address <= FLASH_LAST)
      else $error("level 2 boot outside flash");
   a_hold_addr: assert property (o_boot_valid && $past(o_boot_valid)
      |-> $stable(o_boot_address) && $stable(o_boot_source))
      else $error("decision changed while held");
   a_start_secure: assert property ($rose(o_boot_valid) |-> o_start_secure)
      else $error("core not started secure");
   a_pready_next: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready in access cycle");
endmodule
bind boot_address_select boot_address_select_sva chk_u (.*);

// >>> verification/boot_address_select_bench.sv
// Self-checking bench of the boot address selector.
`timescale 1ns/1ps
module boot_address_select_bench;
   import boot_address_select_pkg::*;
   `define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
      $display("BAD %s expected %h seen %h", nm, e, s); end end
   // Fields 0x0800_4000, 0x2000_0000 (SRAM) and 0x3000_0000 (outside secure flash).
   localparam logic [FIELD_W-1:0] FA = 25'h010_0080;
   localparam logic [FIELD_W-1:0] FB = 25'h040_0000;
   localparam logic [FIELD_W-1:0] FS = 25'h060_0000;
   // Case bits: valid, pin, option, choice, security, lock, level, command.
   localparam logic [8:0] CASES [18] = '{9'h120, 9'h1A0, 9'h140, 9'h100, 9'h130, 9'h1B0,
      9'h150, 9'h110, 9'h151, 9'h1B9, 9'h132, 9'h1A6, 9'h126, 9'h020, 9'h0A0, 9'h030,
      9'h11E, 9'h034};
   logic i_clk = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic i_boot_select_pin, i_options_valid, i_boot_select_option, i_pin_or_option_choice;
   logic i_security_enable_option, i_boot_lock_option;
   logic [1:0] i_readout_protection_level;
   logic [FIELD_W-1:0] i_nonsecure_boot_address_a = FA, i_nonsecure_boot_address_b = FB;
   logic [FIELD_W-1:0] i_secure_boot_address = FS;
   logic [CMD_W-1:0] i_services_command;
   logic [PADDR_W-1:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, o_boot_address, fetch_addr, q;
   logic o_pready, o_pslverr, o_boot_valid, o_address_forced, o_start_secure, e;
   logic [2:0] o_boot_source;
   int n_fail = 0, samples_checked = 0;
   always #20 i_clk = ~i_clk;
   boot_address_select dut_u (.*);
   boot_core_model core_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_boot_address(o_boot_address),
      .i_boot_valid(o_boot_valid), .i_start_secure(o_start_secure), .o_fetch_address(fetch_addr));
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic setin(input logic [8:0] v);
      {i_options_valid, i_boot_select_pin, i_boot_select_option, i_pin_or_option_choice,
         i_security_enable_option, i_boot_lock_option, i_readout_protection_level} <= v[8:1];
      i_services_command <= v[0] ? 8'h05 : 8'h00;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      i_psel <= 1'h1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_clk);
         k++;
      end while (o_pready !== 1'h1 && k < 20);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
      @(posedge i_clk);
      if (k >= 20) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic wait_valid();
      int k;
      k = 0;
      while (o_boot_valid !== 1'h1 && k < 20) begin
         @(posedge i_clk);
         k++;
      end
      if (k >= 20) begin
         n_fail++;
         summarize();
      end
   endtask
   // Returns forced flag, source and address.
   function automatic logic [35:0] expect_boot(input logic [8:0] v);
      logic sel;
      logic f;
      logic [2:0] s;
      logic [31:0] a;
      sel = v[5] ? v[7] : !v[6];
      f = 1'h0;
      if (v[4]) begin
         s = (v[3] || !(v[0] || sel)) ? SRC_SECURE : SRC_SERVICES;
         a = (s == SRC_SECURE) ? {v[8] ? FS : DEFAULT_FIELD_S, 7'h00} : SERVICES_ENTRY;
         if (v[2:1] != PROT_L0 && a != SERVICES_ENTRY
            && (a < SECURE_FLASH_BASE || a > SECURE_FLASH_LAST)) begin
            {f, s, a} = {1'h1, SRC_SERVICES, SERVICES_ENTRY};
         end
      end else begin
         s = sel ? SRC_NONSECURE_B : SRC_NONSECURE_A;
         a = sel ? {v[8] ? FB : DEFAULT_FIELD_B, 7'h00} : {v[8] ? FA : DEFAULT_FIELD_A, 7'h00};
         if (v[2:1] == PROT_L2 && (a < FLASH_BASE || a > FLASH_LAST)) begin
            {f, s, a} = {1'h1, SRC_FORCED_FLASH, FLASH_BASE};
         end
      end
      return {f, s, a};
   endfunction
   task automatic judge(input logic [8:0] v);
      logic [35:0] x;
      x = expect_boot(v);
      apb(1'h0, REG_STATUS, 32'h0000_0000);
      `CHK("status", {26'h000_0000, x[35], 1'h1, x[34:32], 1'h1}, q)
      apb(1'h0, REG_BOOT_ADDRESS, 32'h0000_0000);
      `CHK("address", x[31:0], q)
      `CHK("fetch", x[31:0], fetch_addr)
      apb(1'h0, REG_OPTIONS, 32'h0000_0000);
      `CHK("options", {20'h0_0000, v[0] ? 4'h5 : 4'h0, v[2:1], v[3], v[4], v[5], v[6], v[7], v[8]}, q)
   endtask
   // ==========================================================================
   // Sequence
   // ==========================================================================
   initial begin
      setin(9'h000);
      repeat (16) @(posedge i_clk);
      i_reset_n <= 1'h1;
      wait_valid();
      foreach (CASES[c]) begin
         setin(CASES[c]);
         apb(1'h1, REG_CONTROL, 32'h0000_0001);
         repeat (2) @(posedge i_clk);
         wait_valid();
         judge(CASES[c]);
         $display("case %0d done", c);
      end
      setin(9'h0B4);
      repeat (5) @(posedge i_clk);
      apb(1'h0, REG_BOOT_ADDRESS, 32'h0000_0000);
      `CHK("held", 32'h0C00_0000, q)
      apb(1'h0, 12'h010, 32'h0000_0000);
      `CHK("unmapped", 1'h1, e)
      apb(1'h1, REG_STATUS, 32'h0000_0000);
      `CHK("read only", 1'h1, e)
      $display("hold and access test done");
      i_reset_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      `CHK("reset valid", 1'h0, o_boot_valid)
      i_reset_n <= 1'h1;
      wait_valid();
      judge(9'h0B4);
      $display("second reset test done");
      summarize();
   end
endmodule
